// File: src/csw_clock_switch.sv
// system clock source selection, oscillator-fail detect, switchback and status
// Function
// - divide field: 00 multiplier, 01 reserved, 10 divide-by-4 default, 11 divide-by-1024
// - factor select bit: 1 gives four times, 0 two times the input clock
// - a newly written rate applies after one machine cycle
// - divide field changes only to or from the divide-by-4 code
// - disallowed divide field writes are dropped, field unchanged
// - factor select writable only while multiplier enable is 0
// - multiplier enable changes only at divide-by-4 with ring mode flag 0
// - clearing multiplier enable disables it, clears ready, starts stabilisation
// - during stabilisation ready stays 0 and multiplier code writes are refused
// - hardware sets ready at timeout end; software cannot set it
// - enabled oscillator failure below limit holds reset until it recovers
// - failure sets flag; cleared only by power-up reset or software 0
// - low-power divide: system clock is input over 256, 1024 per cycle
// - switchback enabled in low-power divide: acknowledged interrupt returns divide-by-4
// - disabled or unacknowledged interrupt activity causes no switchback
// - enabled serial start bit or transmit load returns divide-by-4 at once
// - after switchback divide-by-4 holds until software rewrites the field
// - divide field is write-protected while any serial activity flag is set
// - status bits 7, 6, 5 show power-fail, high, low levels in service
// - status bits 0,1 port 0 receive/transmit; 2,3 port 1
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module csw_clock_switch #(
  parameter int STAB_CYCLES = csw_pkg::STAB_CYCLES_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_ring_mode_flag,
  input wire logic i_osc_below_limit,
  input wire logic i_irq_will_ack,
  input wire logic i_powerfail_level_in_service,
  input wire logic i_high_level_in_service,
  input wire logic i_low_level_in_service,
  input wire logic [1:0] i_uart_enable,
  input wire logic [3:0] i_serial_start,
  input wire logic [3:0] i_serial_done,
  output logic [1:0] o_clock_select,
  output logic o_multiplier_enable,
  output logic o_multiplier_factor_4x,
  output logic o_clock_ready_flag,
  output logic o_sys_clk_en,
  output logic o_machine_cycle_en,
  output logic o_osc_fail_reset,
  output logic o_switchback
);

  localparam logic [csw_pkg::STAB_WIDTH-1:0] STAB_LOAD =
    csw_pkg::STAB_WIDTH'(STAB_CYCLES - 1);

  // software-visible state
  logic [1:0] clock_divide_q;
  logic switchback_enable_q;
  logic crystal_multiplier_enable_q;
  logic multiplier_factor_select_q;
  logic [2:0] pmr_spare_q;
  logic clock_ready_flag_q;
  logic osc_fail_enable_q;
  logic osc_fail_flag_q;
  logic [2:0] level_in_service_q;
  logic [3:0] serial_activity_q;

  // clock generation state
  logic [1:0] clock_applied_q;
  logic [csw_pkg::MC_WIDTH-1:0] mc_count_q;
  logic [csw_pkg::STAB_WIDTH-1:0] stab_count_q;
  logic stab_running_q;

  // decoded register writes
  logic wr_pmr;
  logic wr_power_control_register;
  logic [1:0] cd_new;
  logic cd_write_ok;
  logic serial_busy;
  logic serial_wake;
  logic switchback_now;
  logic ctm_write_ok;
  logic ctm_falling;
  logic [3:0] serial_start_enabled;

  assign wr_pmr = i_wr_en && (i_addr == csw_pkg::ADDR_POWER_MGMT);
  assign wr_power_control_register = i_wr_en && (i_addr == csw_pkg::ADDR_POWER_CTRL);
  assign cd_new = i_wr_data[csw_pkg::CLOCK_DIVIDE_HI_BIT:csw_pkg::CLOCK_DIVIDE_LO_BIT];
  assign serial_busy = |serial_activity_q;

  // serial events only count for a port whose receiver/transmitter is enabled
  genvar ch;
  generate
    for (ch = 0; ch < csw_pkg::SERIAL_CHANNELS; ch++) begin : g_serial
      // one flop per channel keeps each process the sole writer of its variable
      logic activity_q;
      assign serial_start_enabled[ch] = i_serial_start[ch] && i_uart_enable[ch / 2];
      assign serial_activity_q[ch] = activity_q;

      // activity flag: start bit or buffer load until last bit; set wins
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          activity_q <= 1'b0;
        end else if (serial_start_enabled[ch]) begin
          activity_q <= 1'b1;
        end else if (i_serial_done[ch]) begin
          activity_q <= 1'b0;
        end
      end
    end
  endgenerate

  // switchback causes; the controller only raises i_irq_will_ack for an
  // enabled source not locked out by a level already in service
  assign serial_wake = |serial_start_enabled;
  assign switchback_now = switchback_enable_q && (clock_divide_q == csw_pkg::CD_DIV1024) &&
                          (i_irq_will_ack || serial_wake);

  // legal divide transitions: via divide-by-4 only, never the reserved code,
  // no multiplier until ready, nothing while a character is on the wire
  assign cd_write_ok = ((clock_divide_q == csw_pkg::CD_DIV4) ||
                        (cd_new == csw_pkg::CD_DIV4) ||
                        (cd_new == clock_divide_q)) &&
                       (cd_new != csw_pkg::CD_RESERVED) &&
                       !((cd_new == csw_pkg::CD_MULTIPLIER) && !clock_ready_flag_q) &&
                       !serial_busy;

  // multiplier enable only moves at divide-by-4 outside ring mode
  assign ctm_write_ok = (clock_divide_q == csw_pkg::CD_DIV4) && !i_ring_mode_flag;
  assign ctm_falling = wr_pmr && ctm_write_ok && crystal_multiplier_enable_q &&
                       !i_wr_data[csw_pkg::CRYSTAL_MULT_ENABLE_BIT];

  // clock divide field; switchback beats a software write in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clock_divide_q <= csw_pkg::CLOCK_DIVIDE_RESET;
    end else if (switchback_now) begin
      clock_divide_q <= csw_pkg::CD_DIV4;
    end else if (wr_pmr && cd_write_ok) begin
      clock_divide_q <= cd_new;
    end
  end

  // remaining power management bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      switchback_enable_q <= 1'b0;
      crystal_multiplier_enable_q <= 1'b0;
      multiplier_factor_select_q <= 1'b0;
      pmr_spare_q <= csw_pkg::PMR_SPARE_RESET;
    end else if (wr_pmr) begin
      switchback_enable_q <= i_wr_data[csw_pkg::SWITCHBACK_ENABLE_BIT];
      pmr_spare_q <= i_wr_data[csw_pkg::PMR_SPARE_TOP_BIT:0];
      if (ctm_write_ok) begin
        crystal_multiplier_enable_q <= i_wr_data[csw_pkg::CRYSTAL_MULT_ENABLE_BIT];
      end
      // judged on the enable as it stood before this write
      if (!crystal_multiplier_enable_q) begin
        multiplier_factor_select_q <= i_wr_data[csw_pkg::MULT_FACTOR_SELECT_BIT];
      end
    end
  end

  // stabilisation timer; runs from reset so the multiplier is ready once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stab_running_q <= 1'b1;
      stab_count_q <= STAB_LOAD;
      clock_ready_flag_q <= 1'b0;
    end else if (ctm_falling) begin
      stab_running_q <= 1'b1;
      stab_count_q <= STAB_LOAD;
      clock_ready_flag_q <= 1'b0;
    end else if (stab_running_q) begin
      if (stab_count_q == '0) begin
        stab_running_q <= 1'b0;
        clock_ready_flag_q <= 1'b1;
      end else begin
        stab_count_q <= stab_count_q - 1'b1;
      end
    end
  end

  // oscillator-fail enable and flag; detector event wins over a software clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_fail_enable_q <= 1'b0;
      osc_fail_flag_q <= 1'b0;
    end else begin
      if (wr_power_control_register) begin
        osc_fail_enable_q <= i_wr_data[csw_pkg::OSC_FAIL_ENABLE_BIT];
      end
      if (i_osc_below_limit) begin
        osc_fail_flag_q <= 1'b1;
      end else if (wr_power_control_register && !i_wr_data[csw_pkg::OSC_FAIL_FLAG_BIT]) begin
        osc_fail_flag_q <= 1'b0;
      end
    end
  end

  // reset request held as long as the oscillator stays below the limit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_osc_fail_reset <= 1'b0;
    end else begin
      o_osc_fail_reset <= osc_fail_enable_q && i_osc_below_limit;
    end
  end

  // applied selection follows the field at the next machine cycle boundary,
  // so the rate changes part way through a cycle only on a switchback
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clock_applied_q <= csw_pkg::CLOCK_DIVIDE_RESET;
      mc_count_q <= csw_pkg::MC_RELOAD_DIV4;
    end else if (switchback_now) begin
      clock_applied_q <= csw_pkg::CD_DIV4;
      mc_count_q <= csw_pkg::MC_RELOAD_DIV4;
    end else if (mc_count_q == '0) begin
      clock_applied_q <= clock_divide_q;
      case (clock_divide_q)
        csw_pkg::CD_MULTIPLIER: begin
          mc_count_q <= multiplier_factor_select_q ? csw_pkg::MC_RELOAD_MULT4X
                                                   : csw_pkg::MC_RELOAD_MULT2X;
        end
        csw_pkg::CD_DIV1024: begin
          mc_count_q <= csw_pkg::MC_RELOAD_DIV1024;
        end
        default: begin
          mc_count_q <= csw_pkg::MC_RELOAD_DIV4;
        end
      endcase
    end else begin
      mc_count_q <= mc_count_q - 1'b1;
    end
  end

  // clock outputs as enables of the input clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clock_select <= csw_pkg::CLOCK_DIVIDE_RESET;
      o_machine_cycle_en <= 1'b0;
      o_sys_clk_en <= 1'b0;
      o_multiplier_enable <= 1'b0;
      o_multiplier_factor_4x <= 1'b0;
      o_clock_ready_flag <= 1'b0;
      o_switchback <= 1'b0;
    end else begin
      o_clock_select <= clock_applied_q;
      o_machine_cycle_en <= (mc_count_q == '0);
      // a multiplied system clock outruns i_clk, so its enable stays high
      if (clock_applied_q == csw_pkg::CD_DIV1024) begin
        o_sys_clk_en <= ((mc_count_q[7:0] & csw_pkg::PMM_SYS_PHASE_MASK) == 8'h00);
      end else begin
        o_sys_clk_en <= 1'b1;
      end
      o_multiplier_enable <= crystal_multiplier_enable_q;
      o_multiplier_factor_4x <= multiplier_factor_select_q;
      o_clock_ready_flag <= clock_ready_flag_q;
      o_switchback <= switchback_now;
    end
  end

  // interrupt service levels sampled for the status register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_in_service_q <= 3'h0;
    end else begin
      level_in_service_q <= {i_powerfail_level_in_service,
                             i_high_level_in_service,
                             i_low_level_in_service};
    end
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        csw_pkg::ADDR_POWER_MGMT: begin
          o_rd_data <= {clock_divide_q, switchback_enable_q, crystal_multiplier_enable_q,
                        multiplier_factor_select_q, pmr_spare_q};
        end
        csw_pkg::ADDR_RING_OSC_CTRL: begin
          o_rd_data <= {4'h0, clock_ready_flag_q, i_ring_mode_flag, 2'h0};
        end
        csw_pkg::ADDR_POWER_CTRL: begin
          o_rd_data <= {2'h0, osc_fail_flag_q, osc_fail_enable_q, 4'h0};
        end
        csw_pkg::ADDR_STATUS: begin
          o_rd_data <= {level_in_service_q, 1'b0, serial_activity_q};
        end
        default: begin
          o_rd_data <= 8'h00;
        end
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end

endmodule : csw_clock_switch

// File: src/csw_pkg.sv
// constants for the clock switch, power management and switchback block
package csw_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] ADDR_POWER_MGMT = 8'h00;
  localparam logic [7:0] ADDR_RING_OSC_CTRL = 8'h01;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;

  // power_mgmt_register fields
  localparam int CLOCK_DIVIDE_HI_BIT = 7;
  localparam int CLOCK_DIVIDE_LO_BIT = 6;
  localparam int SWITCHBACK_ENABLE_BIT = 5;
  localparam int CRYSTAL_MULT_ENABLE_BIT = 4;
  localparam int MULT_FACTOR_SELECT_BIT = 3;
  localparam int PMR_SPARE_TOP_BIT = 2;

  // ring_osc_control_register fields
  localparam int CLOCK_READY_BIT = 3;
  localparam int RING_MODE_BIT = 2;

  // power_control_register fields
  localparam int OSC_FAIL_FLAG_BIT = 5;
  localparam int OSC_FAIL_ENABLE_BIT = 4;

  // status fields: serial activity in 3..0, service levels in 7..5
  localparam int STATUS_LOW_LEVEL_BIT = 5;
  localparam int STATUS_HIGH_LEVEL_BIT = 6;
  localparam int STATUS_POWERFAIL_LEVEL_BIT = 7;
  localparam int SERIAL_CHANNELS = 4;

  // clock divide codes
  localparam logic [1:0] CD_MULTIPLIER = 2'h0;
  localparam logic [1:0] CD_RESERVED = 2'h1;
  localparam logic [1:0] CD_DIV4 = 2'h2;
  localparam logic [1:0] CD_DIV1024 = 2'h3;

  // reset values
  localparam logic [1:0] CLOCK_DIVIDE_RESET = CD_DIV4;
  localparam logic [2:0] PMR_SPARE_RESET = 3'h0;

  // clocks per machine cycle, as reload values of a down counter
  localparam int MC_WIDTH = 10;
  localparam logic [9:0] MC_RELOAD_MULT4X = 10'h000;
  localparam logic [9:0] MC_RELOAD_MULT2X = 10'h001;
  localparam logic [9:0] MC_RELOAD_DIV4 = 10'h003;
  localparam logic [9:0] MC_RELOAD_DIV1024 = 10'h3FF;
  // in low-power divide the system clock is one input clock in 256
  localparam logic [7:0] PMM_SYS_PHASE_MASK = 8'hFF;

  // multiplier stabilisation timeout, input clock cycles
  localparam int STAB_CYCLES_DEFAULT = 64;
  localparam int STAB_WIDTH = 16;
endpackage : csw_pkg

// File: tb/csw_clock_switch_asserts.sv
// port checks for the clock switch block
`timescale 1ns/100ps
module csw_clock_switch_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_irq_will_ack,
  input wire logic i_osc_below_limit,
  input wire logic [3:0] i_serial_start,
  input wire logic [1:0] o_clock_select,
  input wire logic o_multiplier_enable,
  input wire logic o_multiplier_factor_4x,
  input wire logic o_clock_ready_flag,
  input wire logic o_sys_clk_en,
  input wire logic o_osc_fail_reset,
  input wire logic o_switchback
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // clock code legality and stepping through divide-by-4
  property p_sel_legal; o_clock_select != 2'h1; endproperty
  a_sel_legal: assert property (p_sel_legal) else $error("reserved code");
  property p_sel_step;
    $changed(o_clock_select) |-> o_clock_select == 2'h2 || $past(o_clock_select) == 2'h2;
  endproperty
  a_sel_step: assert property (p_sel_step) else $error("skipped div4");
  // multiplier handshake
  property p_factor_lock; $changed(o_multiplier_factor_4x) |-> !$past(o_multiplier_enable);
  endproperty
  a_factor_lock: assert property (p_factor_lock) else $error("factor moved");
  property p_ready_clear; $fell(o_multiplier_enable) |=> (!o_clock_ready_flag) [*2];
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready kept");
  property p_mult_ready;
    o_clock_select == 2'h0 && $past(o_clock_select) != 2'h0
      |-> o_clock_ready_flag && o_multiplier_enable;
  endproperty
  a_mult_ready: assert property (p_mult_ready) else $error("unready mult");
  // oscillator fail reset needs a low oscillator a cycle earlier
  property p_osc_rst; o_osc_fail_reset |-> $past(i_osc_below_limit); endproperty
  a_osc_rst: assert property (p_osc_rst) else $error("spurious reset");
  property p_sysclk;
    o_clock_select == 2'h2 && $past(o_clock_select) == 2'h2 && $past(i_rst_n) |-> o_sys_clk_en;
  endproperty
  a_sysclk: assert property (p_sysclk) else $error("sys clock gated");
  // switchback lands in div4, only from a real cause
  property p_sb_to; o_switchback |=> (o_clock_select == 2'h2) [*3]; endproperty
  a_sb_to: assert property (p_sb_to) else $error("switchback not div4");
  property p_sb_cause;
    o_switchback |-> $past(i_irq_will_ack) || $past(i_serial_start) != 4'h0;
  endproperty
  a_sb_cause: assert property (p_sb_cause) else $error("switchback no cause");
  c_sb: cover property (o_switchback);
  c_mult: cover property (o_clock_select == 2'h0);
  c_osc: cover property (o_osc_fail_reset);
endmodule : csw_clock_switch_chk
bind csw_clock_switch csw_clock_switch_chk i_chk (.i_clk, .i_rst_n, .i_irq_will_ack,
  .i_osc_below_limit, .i_serial_start, .o_clock_select, .o_multiplier_enable,
  .o_multiplier_factor_4x, .o_clock_ready_flag, .o_sys_clk_en, .o_osc_fail_reset,
  .o_switchback);

// File: tb/csw_clock_switch_bench.sv
// self-checking bench for the clock switch block
`timescale 1ns/100ps
module csw_clock_switch_bench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ring = 1'b0;
  logic osc = 1'b0;
  logic [1:0] uen = 2'h0;
  logic [3:0] st, dn;
  logic [2:0] lv;
  logic ack, sb, mce, sce, rdy, me, fx, ofr;
  logic [1:0] sel;
  logic [7:0] rdat;
  int bad_count = 0;
  int compares = 0;
  always #2.5 i_clk = ~i_clk;
  csw_clock_switch #(.STAB_CYCLES(4)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_wr_data(wdat), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdat),
    .i_ring_mode_flag(ring), .i_osc_below_limit(osc), .i_irq_will_ack(ack),
    .i_powerfail_level_in_service(lv[2]), .i_high_level_in_service(lv[1]),
    .i_low_level_in_service(lv[0]), .i_uart_enable(uen), .i_serial_start(st),
    .i_serial_done(dn), .o_clock_select(sel), .o_multiplier_enable(me),
    .o_multiplier_factor_4x(fx), .o_clock_ready_flag(rdy), .o_sys_clk_en(sce),
    .o_machine_cycle_en(mce), .o_osc_fail_reset(ofr), .o_switchback(sb));
  csw_far_model i_far (.i_clk(i_clk), .o_start(st), .o_done(dn), .o_will_ack(ack),
    .o_svc(lv));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge i_clk);
    wr <= 1'b0;
    // return off the edge so a following compare sees settled outputs
    #1;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    tick(1);
    rd <= 1'b0;
    chk(rdat & m, e);
  endtask : rd_reg
  // bounded wait for an applied clock code
  task automatic wsel(input logic [1:0] c);
    int k;
    k = 0;
    while (sel !== c && k < 1200) begin
      tick(1);
      k++;
    end
    chk({6'h0, sel}, {6'h0, c});
  endtask : wsel
  task automatic cnt(input int n, input logic [7:0] es, input logic [7:0] em);
    logic [7:0] s, m;
    s = 8'h00;
    m = 8'h00;
    repeat (n) begin
      tick(1);
      s += {7'h0, sce === 1'b1};
      m += {7'h0, mce === 1'b1};
    end
    chk(s, es);
    chk(m, em);
  endtask : cnt
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_reg(8'h00, 8'hFF, 8'h80);
    rd_reg(8'h10, 8'hFF, 8'h00);
    cnt(16, 8'h10, 8'h04);
    rd_reg(8'h01, 8'h0C, 8'h08);
    $display("reset test done");
    @(posedge i_clk) ring <= 1'b1;
    wr_reg(8'h00, 8'h90);
    rd_reg(8'h00, 8'hFF, 8'h80);
    @(posedge i_clk) ring <= 1'b0;
    wr_reg(8'h00, 8'h88);
    wr_reg(8'h00, 8'h98);
    wr_reg(8'h00, 8'h90);
    rd_reg(8'h00, 8'hFF, 8'h98);
    chk({6'h0, me, fx}, 8'h03);
    wr_reg(8'h00, 8'h18);
    wsel(2'h0);
    cnt(8, 8'h08, 8'h08);
    wr_reg(8'h00, 8'hD8);
    rd_reg(8'h00, 8'hFF, 8'h18);
    wr_reg(8'h00, 8'h98);
    wsel(2'h2);
    wr_reg(8'h00, 8'h88);
    wr_reg(8'h00, 8'h08);
    chk({7'h0, rdy}, 8'h00);
    rd_reg(8'h00, 8'hFF, 8'h88);
    tick(8);
    chk({6'h0, rdy, fx}, 8'h03);
    wr_reg(8'h00, 8'h98);
    wr_reg(8'h00, 8'h88);
    wr_reg(8'h01, 8'h08);
    chk({7'h0, rdy}, 8'h00);
    $display("multiplier test done");
    wr_reg(8'h00, 8'hE0);
    wsel(2'h3);
    cnt(2048, 8'h08, 8'h02);
    i_far.irq(1'b1, 1'b0);
    tick(8);
    chk({6'h0, sel}, 8'h03);
    i_far.irq(1'b1, 1'b1);
    tick(1);
    chk({7'h0, sb}, 8'h01);
    tick(1);
    chk({5'h0, sb, sel}, 8'h02);
    i_far.irq(1'b0, 1'b0);
    tick(20);
    rd_reg(8'h00, 8'hC0, 8'h80);
    $display("interrupt switchback test done");
    wr_reg(8'h00, 8'hE0);
    wsel(2'h3);
    i_far.go(0);
    rd_reg(8'h03, 8'h0F, 8'h00);
    chk({6'h0, sel}, 8'h03);
    i_far.stop(0);
    @(posedge i_clk) uen <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      i_far.go(i);
      rd_reg(8'h03, 8'h0F, 8'h01 << i);
      wr_reg(8'h00, 8'hE0);
      rd_reg(8'h00, 8'hC0, 8'h80);
      i_far.stop(i);
    end
    rd_reg(8'h03, 8'h0F, 8'h00);
    wr_reg(8'h00, 8'hE0);
    rd_reg(8'h00, 8'hC0, 8'hC0);
    wr_reg(8'h00, 8'hA0);
    $display("serial switchback test done");
    for (int i = 0; i < 3; i++) begin
      i_far.svc(3'h1 << i);
      tick(2);
      rd_reg(8'h03, 8'hE0, 8'h20 << i);
    end
    i_far.svc(3'h0);
    $display("status test done");
    wr_reg(8'h02, 8'h10);
    @(posedge i_clk) osc <= 1'b1;
    tick(3);
    chk({7'h0, ofr}, 8'h01);
    @(posedge i_clk) osc <= 1'b0;
    tick(3);
    chk({7'h0, ofr}, 8'h00);
    wr_reg(8'h02, 8'h30);
    rd_reg(8'h02, 8'h30, 8'h30);
    wr_reg(8'h02, 8'h00);
    rd_reg(8'h02, 8'h30, 8'h00);
    $display("oscillator fail test done");
    results;
  end
  // watchdog well beyond the planned run of some 2300 cycles
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule : csw_clock_switch_bench

// File: tb/csw_far_model.sv
// far side model: two uarts and the interrupt controller
`timescale 1ns/100ps
module csw_far_model (
  input wire logic i_clk,
  output logic [3:0] o_start,
  output logic [3:0] o_done,
  output logic o_will_ack,
  output logic [2:0] o_svc
);
  logic [3:0] st = 4'h0;
  logic [3:0] dn = 4'h0;
  logic [2:0] lv = 3'h0;
  logic pend = 1'b0;
  logic en = 1'b0;
  // any level in service locks the single modelled source out
  assign o_will_ack = pend & en & (lv == 3'h0);
  assign o_start = st;
  assign o_done = dn;
  assign o_svc = lv;
  // a shift runs from start bit or buffer load until its last bit
  task automatic go(input int i);
    @(posedge i_clk);
    st[i] <= 1'b1;
    @(posedge i_clk);
    st[i] <= 1'b0;
  endtask : go
  task automatic stop(input int i);
    @(posedge i_clk);
    dn[i] <= 1'b1;
    @(posedge i_clk);
    dn[i] <= 1'b0;
  endtask : stop
  task automatic irq(input logic p, input logic e);
    @(posedge i_clk);
    pend <= p;
    en <= e;
  endtask : irq
  task automatic svc(input logic [2:0] s);
    @(posedge i_clk);
    lv <= s;
  endtask : svc
endmodule : csw_far_model
